/* File: fault_pkg.sv */
package fault_pkg;
  localparam int CLK_MHZ = 10;
  localparam int NUM_FET = 6;
  localparam int TIMER_W = 24;
  localparam int SLEEP_W = 12;
  localparam int DEG_W = 8;
  localparam int NUM_CH = 5;
  // retry channels
  localparam int CH_REG = 0;
  localparam int CH_REF = 1;
  localparam int CH_PUMP = 2;
  localparam int CH_OCP = 3;
  localparam int CH_SD = 4;
  // times in their own units
  localparam int SHORT_RETRY_US = 5000;
  localparam int LONG_RETRY_US = 1000000;
  localparam int DEG0_NS = 1000;
  localparam int DEG1_NS = 2000;
  localparam int DEG2_NS = 4000;
  localparam int DEG3_NS = 8000;
  localparam int BLANK0_NS = 200;
  localparam int BLANK1_NS = 500;
  localparam int BLANK2_NS = 1000;
  localparam int BLANK3_NS = 2000;
  localparam int RST_PULSE_MAX_US = 20;
  localparam int SLEEP_US = 100;
  localparam int WAKE_US = 200;
  // least times round up, longest times round down
  localparam int SHORT_RETRY_CYC = SHORT_RETRY_US * CLK_MHZ;
  localparam int LONG_RETRY_CYC = LONG_RETRY_US * CLK_MHZ;
  localparam int DEG0_CYC = (DEG0_NS * CLK_MHZ + 999) / 1000;
  localparam int DEG1_CYC = (DEG1_NS * CLK_MHZ + 999) / 1000;
  localparam int DEG2_CYC = (DEG2_NS * CLK_MHZ + 999) / 1000;
  localparam int DEG3_CYC = (DEG3_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK0_CYC = (BLANK0_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK1_CYC = (BLANK1_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK2_CYC = (BLANK2_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK3_CYC = (BLANK3_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_PULSE_CYC = RST_PULSE_MAX_US * CLK_MHZ;
  localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  // overcurrent action and shutdown retry codes
  localparam logic [2:0] OC_LONG = 3'h0;
  localparam logic [2:0] OC_SHORT = 3'h1;
  localparam logic [2:0] OC_LATCH = 3'h2;
  localparam logic [2:0] OC_REPORT = 3'h3;
  localparam logic [2:0] OC_OFF = 3'h7;
  localparam logic [1:0] SD_LONG = 2'h0;
  localparam logic [1:0] SD_SHORT = 2'h1;
  // reset values
  localparam logic REF_EN_RST = 1'h0;
  localparam logic WARN_EN_RST = 1'h0;
  localparam logic UV_SEL_RST = 1'h1;
  localparam logic [2:0] ACT_RST = OC_SHORT;
  localparam logic [1:0] SD_SEL_RST = SD_SHORT;
  localparam logic ERR_N_RST = 1'h1;
endpackage

/* File: interval_timer.sv */
`timescale 1ns/10ps
module interval_timer #(
  parameter int TW = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [TW-1:0] load,
  output logic busy,
  output logic done
);
  logic [TW-1:0] cnt;
  logic [TW-1:0] next_cnt;

  if (TW < 2 || TW > 31) begin : g_bad
    $error("interval_timer: unsupported width");
  end

  // a start while running reloads, so time runs from the last start
  always_comb begin
    next_cnt = cnt;
    if (start) begin
      next_cnt = load;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign busy = cnt != '0;
  assign done = !start && cnt == TW'(1);
endmodule

/* File: fault_protection_sleep_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - regulator undervoltage: FETs and serial off, fault low, three flags set
// - regulator recovery plus retry time resumes; summary flags wait for clear
// - sense reference undervoltage acts only when enabled; amplifiers off
// - sense reference recovery plus retry re-enables amplifiers, clears its flag
// - sense reference check off after reset; always off in pin variant
// - pump undervoltage: FETs and pump off, flags set, retry then resume
// - overcurrent counts only after indication persists through the deglitch time
// - every PWM edge starts a blanking window that masks overcurrent
// - pin variant: 1 us deglitch, 0.2 us blank, short 5 ms retry
// - register variant takes level, deglitch, blank and action from config
// - action 010b: latched shutdown until condition gone and clear command
// - action 000b/001b: off, retry, per-FET flags clear, summaries stay
// - action 011b: FETs run, fault reported until gone and cleared
// - action 111b: overcurrent ignored entirely
// - thermal warning sets flags; reports on fault pin only when enabled
// - warning flag follows temperature; summary clears on clear below trip
// - pin variant never reports thermal warning on the fault pin
// - thermal shutdown: FETs and pump off, flags, retry; always active
// - shutdown retry select 00b long, 01b short; pin variant short
// - sleep pin low beyond sleep delay powers everything down
// - sleep pin high with supply good wakes pump, regulator, serial port
// - fault pin held low while regulators power up or down
// - too long a pulse sleeps; a valid pulse disturbs nothing else
module fault_protection_sleep_ctrl #(
  parameter bit REG_VARIANT = 1'b1,
  parameter int NF = fault_pkg::NUM_FET,
  parameter int TW = fault_pkg::TIMER_W,
  parameter int SHORT_RETRY_CYCLES = fault_pkg::SHORT_RETRY_CYC,
  parameter int LONG_RETRY_CYCLES = fault_pkg::LONG_RETRY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic low_power_request_n_pin,
  input wire logic supply_ok,
  input wire logic regulator_uv,
  input wire logic sense_ref_uv,
  input wire logic pump_uv,
  input wire logic [NF-1:0] fet_oc,
  input wire logic [NF-1:0] pwm,
  input wire logic thermal_warn,
  input wire logic thermal_sd,
  input wire logic sense_ref_check_enable,
  input wire logic [2:0] overcurrent_action_sel,
  input wire logic [1:0] overcurrent_level_sel,
  input wire logic [1:0] overcurrent_deglitch_sel,
  input wire logic [1:0] overcurrent_blank_sel,
  input wire logic warning_report_enable,
  input wire logic [1:0] shutdown_retry_sel,
  input wire logic uv_retry_sel,
  input wire logic clear_errors_bit,
  output logic error_out_n_pin,
  output logic fet_enable,
  output logic sense_amp_enable,
  output logic pump_enable,
  output logic regulator_enable,
  output logic serial_enable,
  output logic [1:0] overcurrent_level,
  output logic global_error_flag,
  output logic undervolt_summary_flag,
  output logic regulator_undervolt_flag,
  output logic sense_ref_undervolt_flag,
  output logic pump_undervolt_flag,
  output logic overcurrent_flag,
  output logic [NF-1:0] fet_oc_flag,
  output logic thermal_summary_flag,
  output logic thermal_warning_flag,
  output logic thermal_shutdown_flag
);
  localparam int DW = fault_pkg::DEG_W;
  localparam int SW = fault_pkg::SLEEP_W;
  localparam int NC = fault_pkg::NUM_CH;
  typedef enum logic [2:0] {S_ACTIVE, S_LOW, S_DOWN, S_ASLEEP, S_WAKE} sleep_t;

  if (NF < 1 || TW < 2 || TW > 31 || SHORT_RETRY_CYCLES < 1 ||
      LONG_RETRY_CYCLES < 1 || SHORT_RETRY_CYCLES >= (1 << TW) ||
      LONG_RETRY_CYCLES >= (1 << TW) ||
      fault_pkg::RST_PULSE_CYC >= fault_pkg::SLEEP_CYC) begin : g_bad
    $error("fault_protection_sleep_ctrl: unsupported parameters");
  end

  logic rs1, rs;
  logic ref_en, next_ref_en, warn_en, next_warn_en, uvsel, next_uvsel;
  logic [2:0] act, next_act;
  logic [1:0] deg_sel, next_deg_sel, blk_sel, next_blk_sel;
  logic [1:0] sd_sel, next_sd_sel;
  logic [DW-1:0] deg_cyc, blk_cyc;
  logic [TW-1:0] long_ld, short_ld;
  logic [TW-1:0] ld [NC];
  logic [NF-1:0] pwm_d, oc_ev;
  logic [DW-1:0] dcnt [NF];
  logic [DW-1:0] next_dcnt [NF];
  logic pwm_edge, blank_busy, blanking, oc_on, oc_hit, oc_cond, clr;
  logic [NC-1:0] cond, done, hold, next_hold, fault_lvl;
  logic oc_latch, next_oc_latch, oc_rep, next_oc_rep, uv_set;
  logic next_glob, next_uvsum, next_ocflag, next_thsum, next_warn;
  logic [NF-1:0] next_fflag;
  sleep_t st, next_st;
  logic [SW-1:0] scnt, next_scnt;
  logic rst_pulse, awake, powered;
  logic next_fet, next_csa, next_pump, next_reg, next_spi, next_err_n;

  //////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1 <= 1'h0;
      rs <= 1'h0;
    end else begin
      rs1 <= 1'h1;
      rs <= rs1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration; pin variant forces its fixed settings
  always_comb begin
    next_ref_en = REG_VARIANT && sense_ref_check_enable;
    next_warn_en = REG_VARIANT && warning_report_enable;
    next_uvsel = REG_VARIANT ? uv_retry_sel : 1'h1;
    next_act = REG_VARIANT ? overcurrent_action_sel : fault_pkg::OC_SHORT;
    next_deg_sel = REG_VARIANT ? overcurrent_deglitch_sel : 2'h0;
    next_blk_sel = REG_VARIANT ? overcurrent_blank_sel : 2'h0;
    next_sd_sel = REG_VARIANT ? shutdown_retry_sel : fault_pkg::SD_SHORT;
  end

  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      ref_en <= fault_pkg::REF_EN_RST;
      warn_en <= fault_pkg::WARN_EN_RST;
      uvsel <= fault_pkg::UV_SEL_RST;
      act <= fault_pkg::ACT_RST;
      deg_sel <= 2'h0;
      blk_sel <= 2'h0;
      sd_sel <= fault_pkg::SD_SEL_RST;
      overcurrent_level <= 2'h0;
    end else begin
      ref_en <= next_ref_en;
      warn_en <= next_warn_en;
      uvsel <= next_uvsel;
      act <= next_act;
      deg_sel <= next_deg_sel;
      blk_sel <= next_blk_sel;
      sd_sel <= next_sd_sel;
      overcurrent_level <= overcurrent_level_sel;
    end
  end

  always_comb begin
    case (deg_sel)
      2'h0: deg_cyc = DW'(fault_pkg::DEG0_CYC);
      2'h1: deg_cyc = DW'(fault_pkg::DEG1_CYC);
      2'h2: deg_cyc = DW'(fault_pkg::DEG2_CYC);
      default: deg_cyc = DW'(fault_pkg::DEG3_CYC);
    endcase
    case (blk_sel)
      2'h0: blk_cyc = DW'(fault_pkg::BLANK0_CYC);
      2'h1: blk_cyc = DW'(fault_pkg::BLANK1_CYC);
      2'h2: blk_cyc = DW'(fault_pkg::BLANK2_CYC);
      default: blk_cyc = DW'(fault_pkg::BLANK3_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // blanking and deglitch
  assign pwm_edge = |(pwm ^ pwm_d);
  assign blanking = pwm_edge || blank_busy;

  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      pwm_d <= '0;
    end else begin
      pwm_d <= pwm;
    end
  end

  interval_timer #(.TW(TW)) u_blank (
    .clk(clk),
    .rst_n(rs),
    .start(pwm_edge),
    .load(TW'(blk_cyc)),
    .busy(blank_busy),
    .done()
  );

  for (genvar i = 0; i < NF; i++) begin : g_deg
    // the count saturates, so a held indication gives one event only
    always_comb begin
      next_dcnt[i] = dcnt[i];
      if (blanking || !fet_oc[i]) begin
        next_dcnt[i] = '0;
      end else if (dcnt[i] != deg_cyc) begin
        next_dcnt[i] = dcnt[i] + 1'h1;
      end
    end
    assign oc_ev[i] = next_dcnt[i] == deg_cyc && dcnt[i] != deg_cyc;
    always_ff @(posedge clk or negedge rs) begin
      if (!rs) begin
        dcnt[i] <= '0;
      end else begin
        dcnt[i] <= next_dcnt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // retry channels; a cause held high keeps reloading its timer
  assign oc_on = act <= fault_pkg::OC_REPORT;
  assign oc_hit = (|oc_ev) && oc_on;
  assign oc_cond = |fet_oc;
  assign long_ld = TW'(LONG_RETRY_CYCLES);
  assign short_ld = TW'(SHORT_RETRY_CYCLES);
  assign cond[fault_pkg::CH_REG] = regulator_uv;
  assign cond[fault_pkg::CH_REF] = sense_ref_uv && ref_en;
  assign cond[fault_pkg::CH_PUMP] = pump_uv;
  assign cond[fault_pkg::CH_OCP] = oc_hit && act <= fault_pkg::OC_SHORT;
  assign cond[fault_pkg::CH_SD] = thermal_sd;
  assign ld[fault_pkg::CH_REG] = uvsel ? short_ld : long_ld;
  assign ld[fault_pkg::CH_REF] = uvsel ? short_ld : long_ld;
  assign ld[fault_pkg::CH_PUMP] = uvsel ? short_ld : long_ld;
  assign ld[fault_pkg::CH_OCP] =
    act == fault_pkg::OC_LONG ? long_ld : short_ld;
  assign ld[fault_pkg::CH_SD] =
    sd_sel == fault_pkg::SD_LONG ? long_ld : short_ld;

  for (genvar c = 0; c < NC; c++) begin : g_retry
    interval_timer #(.TW(TW)) u_tmr (
      .clk(clk),
      .rst_n(rs),
      .start(cond[c]),
      .load(ld[c]),
      .busy(),
      .done(done[c])
    );
  end

  assign fault_lvl = cond | hold;
  assign rst_pulse = st == S_LOW && low_power_request_n_pin;
  assign clr = (REG_VARIANT && clear_errors_bit) || rst_pulse;

  //////////////////////////////////////////////////////////////////////
  // flags; every set wins over a clear in the same cycle
  always_comb begin
    next_hold = cond | (hold & ~done);
    uv_set = |cond[fault_pkg::CH_PUMP:fault_pkg::CH_REG];
    next_uvsum = uv_set || (undervolt_summary_flag && !clr);
    next_oc_latch = (oc_hit && act == fault_pkg::OC_LATCH) ||
      (oc_latch && !(clr && !oc_cond));
    next_oc_rep = (oc_hit && act == fault_pkg::OC_REPORT) ||
      (oc_rep && !(clr && !oc_cond));
    next_ocflag = oc_hit || (overcurrent_flag && !(clr && !oc_cond));
    next_fflag = (oc_ev & {NF{oc_on}}) | (fet_oc_flag &
      ~{NF{done[fault_pkg::CH_OCP] || (clr && !oc_cond)}});
    next_warn = thermal_warn;
    next_thsum = thermal_warn || thermal_sd ||
      (thermal_summary_flag && !(clr && !thermal_warn));
    next_glob = uv_set || oc_hit || thermal_sd ||
      (global_error_flag && !clr);
  end

  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      hold <= '0;
      oc_latch <= 1'h0;
      oc_rep <= 1'h0;
      undervolt_summary_flag <= 1'h0;
      overcurrent_flag <= 1'h0;
      fet_oc_flag <= '0;
      thermal_warning_flag <= 1'h0;
      thermal_summary_flag <= 1'h0;
      global_error_flag <= 1'h0;
    end else begin
      hold <= next_hold;
      oc_latch <= next_oc_latch;
      oc_rep <= next_oc_rep;
      undervolt_summary_flag <= next_uvsum;
      overcurrent_flag <= next_ocflag;
      fet_oc_flag <= next_fflag;
      thermal_warning_flag <= next_warn;
      thermal_summary_flag <= next_thsum;
      global_error_flag <= next_glob;
    end
  end

  assign regulator_undervolt_flag = hold[fault_pkg::CH_REG];
  assign sense_ref_undervolt_flag = hold[fault_pkg::CH_REF];
  assign pump_undervolt_flag = hold[fault_pkg::CH_PUMP];
  assign thermal_shutdown_flag = hold[fault_pkg::CH_SD];

  //////////////////////////////////////////////////////////////////////
  // sleep control; a pin rising during power-down waits for sleep first
  always_comb begin
    next_st = st;
    next_scnt = scnt + 1'h1;
    case (st)
      S_ACTIVE: begin
        next_scnt = '0;
        if (!low_power_request_n_pin) next_st = S_LOW;
      end
      S_LOW: begin
        if (low_power_request_n_pin) begin
          next_st = S_ACTIVE;
        end else if (scnt == SW'(fault_pkg::RST_PULSE_CYC - 1)) begin
          next_st = S_DOWN;
        end
      end
      S_DOWN: begin
        if (scnt == SW'(fault_pkg::SLEEP_CYC - 1)) next_st = S_ASLEEP;
      end
      S_ASLEEP: begin
        next_scnt = '0;
        if (low_power_request_n_pin && supply_ok) next_st = S_WAKE;
      end
      S_WAKE: begin
        if (scnt == SW'(fault_pkg::WAKE_CYC - 1)) next_st = S_ACTIVE;
      end
      default: next_st = S_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      st <= S_ACTIVE;
      scnt <= '0;
    end else begin
      st <= next_st;
      scnt <= next_scnt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gating and fault pin
  assign awake = st == S_ACTIVE || st == S_LOW;
  assign powered = st != S_ASLEEP;

  always_comb begin
    next_fet = awake && !fault_lvl[fault_pkg::CH_REG] &&
      !fault_lvl[fault_pkg::CH_PUMP] && !fault_lvl[fault_pkg::CH_SD] &&
      !fault_lvl[fault_pkg::CH_OCP] && !next_oc_latch;
    next_csa = awake && !fault_lvl[fault_pkg::CH_REF];
    next_pump = powered && !fault_lvl[fault_pkg::CH_PUMP] &&
      !fault_lvl[fault_pkg::CH_SD];
    next_reg = powered;
    next_spi = powered && !fault_lvl[fault_pkg::CH_REG];
    next_err_n = !(|fault_lvl || next_oc_latch || next_oc_rep ||
      (thermal_warn && warn_en) || st == S_DOWN || st == S_WAKE);
  end

  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      fet_enable <= 1'h0;
      sense_amp_enable <= 1'h0;
      pump_enable <= 1'h0;
      regulator_enable <= 1'h0;
      serial_enable <= 1'h0;
      error_out_n_pin <= fault_pkg::ERR_N_RST;
    end else begin
      fet_enable <= next_fet;
      sense_amp_enable <= next_csa;
      pump_enable <= next_pump;
      regulator_enable <= next_reg;
      serial_enable <= next_spi;
      error_out_n_pin <= next_err_n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rs);

  property p_uv_off;
    regulator_uv |=> !fet_enable && !serial_enable && !error_out_n_pin &&
      regulator_undervolt_flag && undervolt_summary_flag && global_error_flag;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("regulator uv response");
  property p_ref_gate;
    !ref_en && !sense_ref_undervolt_flag |=> !sense_ref_undervolt_flag;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("ref uv not gated");
  property p_pump;
    pump_uv |=> !pump_enable && !fet_enable && pump_undervolt_flag;
  endproperty
  a_pump: assert property (p_pump) else $error("pump uv response");
  property p_deg;
    oc_ev[0] |-> fet_oc[0] && $past(fet_oc[0], 9);
  endproperty
  a_deg: assert property (p_deg) else $error("overcurrent not deglitched");
  property p_blank;
    pwm_edge |-> !(|oc_ev) ##1 !(|oc_ev);
  endproperty
  a_blank: assert property (p_blank) else $error("overcurrent in blanking");
  property p_latch;
    oc_latch && !clr |=> oc_latch && !fet_enable && !error_out_n_pin;
  endproperty
  a_latch: assert property (p_latch) else $error("latched shutdown lost");
  property p_report;
    act == fault_pkg::OC_REPORT && (|oc_ev) |=> oc_rep && overcurrent_flag;
  endproperty
  a_report: assert property (p_report) else $error("report mode flags");
  property p_off;
    act == fault_pkg::OC_OFF && !overcurrent_flag |=> !overcurrent_flag;
  endproperty
  a_off: assert property (p_off) else $error("disabled mode flagged");
  property p_sd;
    thermal_sd |=> !fet_enable && !pump_enable && !error_out_n_pin &&
      thermal_shutdown_flag && thermal_summary_flag && global_error_flag;
  endproperty
  a_sd: assert property (p_sd) else $error("thermal shutdown response");
  property p_sleep;
    st == S_DOWN |-> ##[1:1000] st == S_ASLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not reached");
  property p_wake;
    st == S_ASLEEP && low_power_request_n_pin && supply_ok |=> st == S_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sequence");
  // wake outlasts any delay range, so a counter apart from scnt bounds it
  logic [SW-1:0] wake_len, next_wake_len;
  always_comb begin
    next_wake_len = st == S_WAKE ? wake_len + 1'h1 : '0;
  end
  always_ff @(posedge clk or negedge rs) begin
    if (!rs) begin
      wake_len <= '0;
    end else begin
      wake_len <= next_wake_len;
    end
  end
  property p_wake_len;
    st == S_WAKE |-> wake_len < SW'(fault_pkg::WAKE_CYC);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake too long");
  property p_hold_low;
    st == S_WAKE |=> !error_out_n_pin && regulator_enable;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("fault pin in wake");
endmodule

/* File: ctrl_model.sv */
`timescale 1ns/10ps
module ctrl_model (
  input wire logic clk,
  input wire logic error_out_n_pin,
  output logic low_power_request_n_pin
);
  initial low_power_request_n_pin = 1'b1;
  // low phase kept short so only the faults clear
  task automatic reset_pulse(input int low_cyc);
    @(posedge clk) low_power_request_n_pin <= 1'b0;
    repeat (low_cyc) @(posedge clk);
    low_power_request_n_pin <= 1'b1;
  endtask
  task automatic sleep_req();
    @(posedge clk) low_power_request_n_pin <= 1'b0;
  endtask
  // no inputs until the fault pin is let go after wake
  task automatic wake(output bit ok);
    int n;
    bit low_seen;
    @(posedge clk) low_power_request_n_pin <= 1'b1;
    ok = 1'b0;
    low_seen = 1'b0;
    for (n = 0; n < fault_pkg::WAKE_CYC + 4 && !ok; n++) begin
      @(negedge clk);
      low_seen = low_seen || error_out_n_pin === 1'b0;
      ok = low_seen && error_out_n_pin === 1'b1;
    end
  endtask
endmodule

/* File: fault_protection_sleep_ctrl_tb_top.sv */
`timescale 1ns/10ps
module fault_protection_sleep_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regulator_uv = 1'b0, sense_ref_uv = 1'b0, pump_uv = 1'b0;
  logic thermal_warn = 1'b0, thermal_sd = 1'b0;
  logic sense_ref_check_enable = 1'b0, warning_report_enable = 1'b0;
  logic clear_errors_bit = 1'b0, uv_retry_sel = 1'b1;
  logic [1:0] shutdown_retry_sel = 2'h1;
  logic [5:0] fet_oc = 6'h00, pwm = 6'h00, fet_oc_flag;
  logic [2:0] overcurrent_action_sel = 3'h1;
  logic [1:0] overcurrent_level_sel = 2'h2, overcurrent_level;
  logic low_power_request_n_pin, error_out_n_pin, fet_enable;
  logic sense_amp_enable, pump_enable, regulator_enable, serial_enable;
  logic global_error_flag, undervolt_summary_flag, overcurrent_flag;
  logic regulator_undervolt_flag, sense_ref_undervolt_flag;
  logic pump_undervolt_flag, thermal_summary_flag;
  logic thermal_warning_flag, thermal_shutdown_flag;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int errors = 0, n_compared = 0, i;
  bit ok;
  always #50 clk = ~clk;
  fault_protection_sleep_ctrl #(.SHORT_RETRY_CYCLES(20),
    .LONG_RETRY_CYCLES(40)) i_fault_protection_sleep_ctrl (
    .clk(clk), .rst_n(rst_n),
    .low_power_request_n_pin(low_power_request_n_pin),
    .supply_ok(1'b1), .regulator_uv(regulator_uv),
    .sense_ref_uv(sense_ref_uv), .pump_uv(pump_uv), .fet_oc(fet_oc),
    .pwm(pwm), .thermal_warn(thermal_warn), .thermal_sd(thermal_sd),
    .sense_ref_check_enable(sense_ref_check_enable),
    .overcurrent_action_sel(overcurrent_action_sel),
    .overcurrent_level_sel(overcurrent_level_sel),
    .overcurrent_deglitch_sel(2'h0), .overcurrent_blank_sel(2'h0),
    .warning_report_enable(warning_report_enable),
    .shutdown_retry_sel(shutdown_retry_sel), .uv_retry_sel(uv_retry_sel),
    .clear_errors_bit(clear_errors_bit),
    .error_out_n_pin(error_out_n_pin), .fet_enable(fet_enable),
    .sense_amp_enable(sense_amp_enable), .pump_enable(pump_enable),
    .regulator_enable(regulator_enable), .serial_enable(serial_enable),
    .overcurrent_level(overcurrent_level),
    .global_error_flag(global_error_flag),
    .undervolt_summary_flag(undervolt_summary_flag),
    .regulator_undervolt_flag(regulator_undervolt_flag),
    .sense_ref_undervolt_flag(sense_ref_undervolt_flag),
    .pump_undervolt_flag(pump_undervolt_flag),
    .overcurrent_flag(overcurrent_flag), .fet_oc_flag(fet_oc_flag),
    .thermal_summary_flag(thermal_summary_flag),
    .thermal_warning_flag(thermal_warning_flag),
    .thermal_shutdown_flag(thermal_shutdown_flag)
  );
  ctrl_model i_ctrl_model (
    .clk(clk), .error_out_n_pin(error_out_n_pin),
    .low_power_request_n_pin(low_power_request_n_pin)
  );
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // outputs looked at mid-cycle, after the edge updates land
  task automatic settle(input int n);
    step(n);
    @(negedge clk);
  endtask
  task automatic wait_on(input int which, input logic val, input int bound);
    int n;
    logic s;
    for (n = 0; n < bound; n++) begin
      @(negedge clk);
      case (which)
        0: s = fet_enable;
        1: s = regulator_undervolt_flag;
        2: s = sense_amp_enable;
        3: s = pump_enable;
        default: s = error_out_n_pin;
      endcase
      if (s === val) return;
    end
    errors++;
    wrap_up();
  endtask
  task automatic clear_cmd();
    step(1);
    clear_errors_bit <= 1'b1;
    step(1);
    clear_errors_bit <= 1'b0;
  endtask
  initial begin
    settle(3);
    chk({error_out_n_pin, fet_enable, global_error_flag}, 3'h4);
    step(1);
    rst_n <= 1'b1;
    wait_on(0, 1'b1, 3000);
    chk(overcurrent_level, 2'h2);
    step(1);
    regulator_uv <= 1'b1;
    settle(3);
    chk({fet_enable, serial_enable, error_out_n_pin}, 3'h0);
    chk({global_error_flag, undervolt_summary_flag,
      regulator_undervolt_flag}, 3'h7);
    step(1);
    regulator_uv <= 1'b0;
    settle(10);
    chk(regulator_undervolt_flag, 1'b1);
    wait_on(0, 1'b1, 40);
    chk({error_out_n_pin, regulator_undervolt_flag, undervolt_summary_flag,
      global_error_flag}, 4'hB);
    clear_cmd();
    settle(2);
    chk({undervolt_summary_flag, global_error_flag}, 2'h0);
    step(1);
    sense_ref_uv <= 1'b1;
    settle(4);
    chk({sense_amp_enable, sense_ref_undervolt_flag}, 2'h2);
    step(1);
    sense_ref_check_enable <= 1'b1;
    settle(4);
    chk({sense_amp_enable, sense_ref_undervolt_flag, error_out_n_pin,
      undervolt_summary_flag, fet_enable}, 5'h0B);
    step(1);
    sense_ref_uv <= 1'b0;
    wait_on(2, 1'b1, 40);
    chk({sense_ref_undervolt_flag, undervolt_summary_flag}, 2'h1);
    step(1);
    sense_ref_check_enable <= 1'b0;
    uv_retry_sel <= 1'b0;
    pump_uv <= 1'b1;
    settle(3);
    chk({fet_enable, pump_enable, error_out_n_pin,
      pump_undervolt_flag}, 4'h1);
    step(1);
    pump_uv <= 1'b0;
    settle(25);
    chk(pump_undervolt_flag, 1'b1);
    wait_on(3, 1'b1, 40);
    chk(pump_undervolt_flag, 1'b0);
    clear_cmd();
    for (i = 0; i < 5; i++) begin
      step(1);
      overcurrent_action_sel <= modes[i];
      step(3);
      fet_oc <= 6'h01;
      settle(8);
      chk(overcurrent_flag, 1'b0);
      settle(5);
      chk(fet_enable, i >= 3);
      chk(error_out_n_pin, i == 4);
      chk({overcurrent_flag, fet_oc_flag, global_error_flag},
        (i == 4) ? 8'h00 : 8'h83);
      step(1);
      fet_oc <= 6'h00;
      settle(24);
      chk(fet_enable, i == 1 || i >= 3);
      settle(40);
      chk(fet_enable, i != 2);
      chk({error_out_n_pin, fet_oc_flag[0]},
        (i == 2 || i == 3) ? 2'h1 : 2'h2);
      chk(overcurrent_flag, i != 4);
      clear_cmd();
      settle(3);
      chk({fet_enable, error_out_n_pin, overcurrent_flag}, 3'h6);
    end
    // pwm edges every two cycles keep the deglitch count from filling
    step(1);
    overcurrent_action_sel <= 3'h1;
    step(3);
    fet_oc <= 6'h02;
    repeat (15) begin
      step(2);
      pwm <= ~pwm;
    end
    settle(1);
    chk(overcurrent_flag, 1'b0);
    step(1);
    fet_oc <= 6'h00;
    thermal_warn <= 1'b1;
    overcurrent_level_sel <= 2'h1;
    settle(3);
    chk(overcurrent_level, 2'h1);
    chk({thermal_warning_flag, thermal_summary_flag, error_out_n_pin,
      fet_enable, global_error_flag}, 5'h1E);
    step(1);
    warning_report_enable <= 1'b1;
    settle(3);
    chk(error_out_n_pin, 1'b0);
    clear_cmd();
    settle(2);
    chk(thermal_summary_flag, 1'b1);
    step(1);
    thermal_warn <= 1'b0;
    settle(3);
    chk({thermal_warning_flag, error_out_n_pin,
      thermal_summary_flag}, 3'h3);
    clear_cmd();
    settle(2);
    chk(thermal_summary_flag, 1'b0);
    step(1);
    warning_report_enable <= 1'b0;
    shutdown_retry_sel <= 2'h0;
    thermal_sd <= 1'b1;
    settle(3);
    chk({fet_enable, pump_enable, error_out_n_pin, thermal_shutdown_flag,
      global_error_flag}, 5'h03);
    step(1);
    thermal_sd <= 1'b0;
    settle(30);
    chk(fet_enable, 1'b0);
    wait_on(0, 1'b1, 32);
    chk(thermal_shutdown_flag, 1'b0);
    i_ctrl_model.reset_pulse(10);
    settle(3);
    chk({global_error_flag, thermal_summary_flag, regulator_enable,
      fet_enable}, 4'h3);
    i_ctrl_model.sleep_req();
    settle(300);
    chk({error_out_n_pin, fet_enable}, 2'h0);
    wait_on(4, 1'b1, 1200);
    chk({pump_enable, serial_enable, sense_amp_enable,
      regulator_enable}, 4'h0);
    i_ctrl_model.wake(ok);
    chk(ok, 1'b1);
    settle(1);
    chk({regulator_enable, pump_enable, serial_enable}, 3'h7);
    wrap_up();
  end
endmodule
